/* rtl/lpd_map.vh */
// Summary of operation
// - Text cursor Y: 13 bits, written and updated
// - Coordinates split low byte, high bits 4..0
// - Control bit 7 written one starts drawing
// - Control bit 7 written zero halts drawing
// - Control bit 7 reads busy status
// - Bit 5 selects outline or filled triangle
// - Bits 4..1 pick line through polylines
// - Ellipse, rounded rectangle, quarter arcs; two unassigned
// - Bit 0 polyline open or closed, read-only
// - Points 1, 2 are first two vertices
// - Point 3 X is the third vertex
// - Point 3 Y in next byte pair
// - Coincident triangle vertices degrade to line or dot
`ifndef LPD_MAP_VH
`define LPD_MAP_VH
`define LPD_ADDR_W        8
`define LPD_COORD_W       13
`define LPD_HI_W          5
`define LPD_A_CURY_LO     8'h65
`define LPD_A_CURY_HI     8'h66
`define LPD_A_CTRL        8'h67
`define LPD_A_P1X_LO      8'h68
`define LPD_A_P1X_HI      8'h69
`define LPD_A_P1Y_LO      8'h6A
`define LPD_A_P1Y_HI      8'h6B
`define LPD_A_P2X_LO      8'h6C
`define LPD_A_P2X_HI      8'h6D
`define LPD_A_P2Y_LO      8'h6E
`define LPD_A_P2Y_HI      8'h6F
`define LPD_A_P3X_LO      8'h70
`define LPD_A_P3X_HI      8'h71
`define LPD_A_P3Y_LO      8'h72
`define LPD_A_P3Y_HI      8'h73
`define LPD_A_IRQ_STAT    8'h74
`define LPD_A_IRQ_MASK    8'h75
`define LPD_CTRL_START    7
`define LPD_CTRL_FILL     5
`define LPD_SHAPE_LSB     1
`define LPD_SHAPE_MSB     4
`define LPD_CTRL_CLOSE    0
`define LPD_SH_LINE       4'h0
`define LPD_SH_TRI        4'h1
`define LPD_SH_RECT       4'h2
`define LPD_SH_QUAD       4'h3
`define LPD_SH_PENT       4'h4
`define LPD_SH_PL3        4'h5
`define LPD_SH_PL4        4'h6
`define LPD_SH_PL5        4'h7
`define LPD_SH_ELL        4'h8
`define LPD_SH_RREC       4'h9
`define LPD_SH_NA0        4'hA
`define LPD_SH_NA1        4'hB
`define LPD_SH_ARC1       4'hC
`define LPD_SH_ARC4       4'hF
`define LPD_KIND_LINE     3'h0
`define LPD_KIND_TRI      3'h1
`define LPD_KIND_DOT      3'h2
`define LPD_KIND_POLY     3'h3
`define LPD_KIND_CURVE    3'h4
`define LPD_KIND_NONE     3'h7
`define LPD_IRQ_DONE      0
`define LPD_IRQ_HALT      1
`define LPD_IRQ_BAD       2
`define LPD_IRQ_W         3
`define LPD_SEG_CYCLES    16'h0010
`define LPD_ZERO8         8'h00
`endif

/* rtl/lpd_engine.v */
`default_nettype none
`include "lpd_map.vh"

// Stand-in for the raster engine: walks the segments of the latched shape,
// spending a fixed number of cycles on each, and steps the text cursor row.
module lpd_engine #(
    parameter SEG_CYCLES = `LPD_SEG_CYCLES
) (
    // Clock and reset
    input  wire        clk,
    input  wire        nrst,
    // Job
    input  wire        go,
    input  wire        halt,
    input  wire [2:0]  kind,
    input  wire [2:0]  segs,
    // Status
    output reg         busy_r,
    output reg         done_r,
    output reg         step_r
);
    reg [15:0] cnt_r;
    reg [2:0]  seg_r;

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
            step_r <= 1'b0;
            cnt_r  <= 16'h0000;
            seg_r  <= 3'h0;
        end else begin
            done_r <= 1'b0;
            step_r <= 1'b0;
            if (halt) begin
                busy_r <= 1'b0;
            end else if (go && !busy_r) begin
                busy_r <= 1'b1;
                cnt_r  <= SEG_CYCLES[15:0] - 16'h0001;
                seg_r  <= segs;
            end else if (busy_r) begin
                if (cnt_r != 16'h0000) begin
                    cnt_r <= cnt_r - 16'h0001;
                end else if (seg_r <= 3'h1 || kind == `LPD_KIND_DOT) begin
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                    step_r <= 1'b1;
                end else begin
                    seg_r  <= seg_r - 3'h1;
                    cnt_r  <= SEG_CYCLES[15:0] - 16'h0001;
                    step_r <= 1'b1;
                end
            end
        end
    end
endmodule // lpd_engine
`default_nettype wire

/* rtl/lpd_draw_ctrl.v */
`default_nettype none
`include "lpd_map.vh"

module lpd_draw_ctrl #(
    parameter SEG_CYCLES = `LPD_SEG_CYCLES
) (
    // Clock and reset
    input  wire        clk,
    input  wire        nrst,
    // Register port
    input  wire [7:0]  addr,
    input  wire [7:0]  wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [7:0]  rdata_r,
    // Drawing job, latched at start
    output reg         busy_r,
    output reg  [3:0]  job_shape_r,
    output reg         job_fill_r,
    output reg         job_close_r,
    output reg  [2:0]  job_kind_r,
    output reg  [12:0] job_x1_r,
    output reg  [12:0] job_y1_r,
    output reg  [12:0] job_x2_r,
    output reg  [12:0] job_y2_r,
    output reg  [12:0] job_x3_r,
    output reg  [12:0] job_y3_r,
    // Interrupt
    output reg         irq_r
);
    localparam NPT = 7;

    // Coordinate array: 0 cursor Y, 1 P1X, 2 P1Y, 3 P2X, 4 P2Y, 5 P3X, 6 P3Y
    reg  [12:0] crd_r [0:NPT-1];
    reg         fill_r;
    reg  [3:0]  shape_r;
    reg         close_r;
    reg  [2:0]  ist_r;
    reg  [2:0]  imask_r;
    reg         go_r;
    reg         halt_r;
    reg  [2:0]  segs_r;
    wire        eng_done;
    wire        eng_step;
    wire [7:0]  lo_idx;
    wire [7:0]  hi_idx;
    wire        start_ok;
    wire [2:0]  slot;
    wire        slot_hi;
    wire        in_crd;
    wire        ctrl_wr;
    wire        p12_same;
    wire        p13_same;
    wire        p23_same;
    reg  [2:0]  kind_nxt;
    reg  [2:0]  segs_nxt;
    reg  [2:0]  ist_nxt;
    reg  [7:0]  rdata_nxt;
    integer     k;

    // Byte pairs start at the cursor row register; slot picks the pair
    assign lo_idx  = addr - `LPD_A_CURY_LO;
    assign in_crd  = (addr >= `LPD_A_CURY_LO) && (addr <= `LPD_A_P3Y_HI) &&
                     (addr != `LPD_A_CTRL);
    // Above the control byte the pairs are shifted by one address
    assign hi_idx  = lo_idx - 8'h01;
    assign slot    = (addr < `LPD_A_CTRL) ? 3'h0 : hi_idx[3:1];
    assign slot_hi = (addr < `LPD_A_CTRL) ? lo_idx[0] : hi_idx[0];
    assign ctrl_wr = wr && (addr == `LPD_A_CTRL);
    // The engine may still be dropping a halt; its go lands after the halt pulse
    assign start_ok = ctrl_wr && wdata[`LPD_CTRL_START] && !busy_r &&
                      (kind_nxt != `LPD_KIND_NONE);

    assign p12_same = (crd_r[1] == crd_r[3]) && (crd_r[2] == crd_r[4]);
    assign p13_same = (crd_r[1] == crd_r[5]) && (crd_r[2] == crd_r[6]);
    assign p23_same = (crd_r[3] == crd_r[5]) && (crd_r[4] == crd_r[6]);

    // Decide what the engine actually draws and how many segments
    always @* begin
        kind_nxt = `LPD_KIND_POLY;
        segs_nxt = 3'h1;
        case (wdata[`LPD_SHAPE_MSB:`LPD_SHAPE_LSB])
            `LPD_SH_LINE: begin
                kind_nxt = `LPD_KIND_LINE;
            end
            `LPD_SH_TRI: begin
                if (p12_same && p13_same) begin
                    kind_nxt = `LPD_KIND_DOT;
                end else if (p12_same || p13_same || p23_same) begin
                    kind_nxt = `LPD_KIND_LINE;
                end else begin
                    kind_nxt = `LPD_KIND_TRI;
                    segs_nxt = 3'h3;
                end
            end
            `LPD_SH_RECT: segs_nxt = 3'h4;
            `LPD_SH_QUAD: segs_nxt = 3'h4;
            `LPD_SH_PENT: segs_nxt = 3'h5;
            `LPD_SH_PL3:  segs_nxt = close_r ? 3'h3 : 3'h2;
            `LPD_SH_PL4:  segs_nxt = close_r ? 3'h4 : 3'h3;
            `LPD_SH_PL5:  segs_nxt = close_r ? 3'h5 : 3'h4;
            `LPD_SH_NA0, `LPD_SH_NA1: begin
                kind_nxt = `LPD_KIND_NONE;
            end
            default: begin
                kind_nxt = `LPD_KIND_CURVE;
                segs_nxt = (wdata[`LPD_SHAPE_MSB:`LPD_SHAPE_LSB] >= `LPD_SH_ARC1) ?
                           3'h1 : 3'h4;
            end
        endcase
    end

    // Register writes; coordinates keep a 5-bit high byte
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (k = 0; k < NPT; k = k + 1) begin
                crd_r[k] <= 13'h0000;
            end
            fill_r  <= 1'b0;
            shape_r <= 4'h0;
            close_r <= 1'b0;
            imask_r <= 3'h0;
        end else begin
            if (wr && in_crd) begin
                if (slot_hi) begin
                    crd_r[slot][12:8] <= wdata[`LPD_HI_W-1:0];
                end else begin
                    crd_r[slot][7:0] <= wdata;
                end
            end
            // Only a host write to the cursor row itself beats the engine step
            if (eng_step && !(wr && in_crd && slot == 3'h0)) begin
                crd_r[0] <= crd_r[0] + 13'h0001;
            end
            if (ctrl_wr) begin
                fill_r  <= wdata[`LPD_CTRL_FILL];
                shape_r <= wdata[`LPD_SHAPE_MSB:`LPD_SHAPE_LSB];
            end
            if (wr && addr == `LPD_A_IRQ_MASK) begin
                imask_r <= wdata[`LPD_IRQ_W-1:0];
            end
        end
    end

    // Start, halt and latching of the job
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            go_r        <= 1'b0;
            halt_r      <= 1'b0;
            segs_r      <= 3'h0;
            job_shape_r <= 4'h0;
            job_fill_r  <= 1'b0;
            job_close_r <= 1'b0;
            job_kind_r  <= 3'h0;
            job_x1_r    <= 13'h0000;
            job_y1_r    <= 13'h0000;
            job_x2_r    <= 13'h0000;
            job_y2_r    <= 13'h0000;
            job_x3_r    <= 13'h0000;
            job_y3_r    <= 13'h0000;
        end else begin
            go_r   <= 1'b0;
            halt_r <= ctrl_wr && !wdata[`LPD_CTRL_START];
            // Unassigned shape codes never start, so busy cannot stick
            if (start_ok) begin
                go_r        <= 1'b1;
                segs_r      <= segs_nxt;
                job_shape_r <= wdata[`LPD_SHAPE_MSB:`LPD_SHAPE_LSB];
                job_fill_r  <= wdata[`LPD_CTRL_FILL];
                job_close_r <= close_r;
                job_kind_r  <= kind_nxt;
                job_x1_r    <= crd_r[1];
                job_y1_r    <= crd_r[2];
                job_x2_r    <= crd_r[3];
                job_y2_r    <= crd_r[4];
                job_x3_r    <= crd_r[5];
                job_y3_r    <= crd_r[6];
            end
        end
    end

    lpd_engine #(
        .SEG_CYCLES (SEG_CYCLES)
    ) u_eng (
        .clk    (clk),
        .nrst   (nrst),
        .go     (go_r),
        .halt   (halt_r),
        .kind   (job_kind_r),
        .segs   (segs_r),
        .busy_r (),
        .done_r (eng_done),
        .step_r (eng_step)
    );

    // Busy as seen by software rises the cycle after the start write
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            busy_r <= 1'b0;
        end else if (ctrl_wr && !wdata[`LPD_CTRL_START]) begin
            busy_r <= 1'b0;
        end else if (start_ok) begin
            busy_r <= 1'b1;
        end else if (eng_done) begin
            busy_r <= 1'b0;
        end
    end

    // Sticky events: done, halted, refused start; set wins over clear
    always @* begin
        ist_nxt = ist_r;
        if (wr && addr == `LPD_A_IRQ_STAT) begin
            ist_nxt = ist_r & ~wdata[`LPD_IRQ_W-1:0];
        end
        if (eng_done) begin
            ist_nxt[`LPD_IRQ_DONE] = 1'b1;
        end
        if (ctrl_wr && !wdata[`LPD_CTRL_START] && busy_r) begin
            ist_nxt[`LPD_IRQ_HALT] = 1'b1;
        end
        if (ctrl_wr && wdata[`LPD_CTRL_START] &&
            (busy_r || kind_nxt == `LPD_KIND_NONE)) begin
            ist_nxt[`LPD_IRQ_BAD] = 1'b1;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ist_r <= 3'h0;
            irq_r <= 1'b0;
        end else begin
            ist_r <= ist_nxt;
            irq_r <= |(ist_nxt & imask_r);
        end
    end

    // Read path; unused bits and unmapped addresses read zero
    always @* begin
        rdata_nxt = `LPD_ZERO8;
        if (in_crd) begin
            rdata_nxt = slot_hi ? {3'h0, crd_r[slot][12:8]} : crd_r[slot][7:0];
        end else if (addr == `LPD_A_CTRL) begin
            rdata_nxt = {busy_r, 1'b0, fill_r, shape_r, close_r};
        end else if (addr == `LPD_A_IRQ_STAT) begin
            rdata_nxt = {5'h00, ist_r};
        end else if (addr == `LPD_A_IRQ_MASK) begin
            rdata_nxt = {5'h00, imask_r};
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= `LPD_ZERO8;
        end else if (rd) begin
            rdata_r <= rdata_nxt;
        end else begin
            rdata_r <= `LPD_ZERO8;
        end
    end
endmodule // lpd_draw_ctrl
`default_nettype wire

/* verif/lpd_draw_ctrl_monitor.sv */
`default_nettype none
`include "lpd_map.vh"

module lpd_draw_ctrl_monitor #(
    parameter SEG_CYCLES = 16
) (
    // Clock and reset
    input wire logic        clk,
    input wire logic        nrst,
    // Register port
    input wire logic [7:0]  addr,
    input wire logic [7:0]  wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [7:0]  rdata_r,
    // Job
    input wire logic        busy_r,
    input wire logic [3:0]  job_shape_r,
    input wire logic        job_fill_r,
    input wire logic        job_close_r,
    input wire logic [2:0]  job_kind_r,
    input wire logic [12:0] job_x1_r,
    input wire logic [12:0] job_y1_r,
    input wire logic [12:0] job_x2_r,
    input wire logic [12:0] job_y2_r,
    input wire logic [12:0] job_x3_r,
    input wire logic [12:0] job_y3_r,
    // Interrupt
    input wire logic        irq_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    wire ctl_wr = wr && addr == `LPD_A_CTRL;
    wire ctl_rd = rd && addr == `LPD_A_CTRL;
    wire na     = wdata[4:1] == `LPD_SH_NA0 || wdata[4:1] == `LPD_SH_NA1;
    wire hi_a   = addr inside {8'h66, 8'h69, 8'h6B, 8'h6D, 8'h6F, 8'h71, 8'h73};
    wire p12    = job_x1_r == job_x2_r && job_y1_r == job_y2_r;
    wire p13    = job_x1_r == job_x3_r && job_y1_r == job_y3_r;
    wire is_tri = job_shape_r == `LPD_SH_TRI;

    a_hi_unused: assert property (rd && hi_a |=> rdata_r[7:5] == 3'h0)
        else $error("unused high coordinate bits read nonzero");
    a_ctrl_fixed: assert property (ctl_rd |=> rdata_r[6] == 1'b0 && rdata_r[0] == 1'b0)
        else $error("control bit 6 or bit 0 read nonzero");
    a_busy_read: assert property (ctl_rd |=> rdata_r[7] == busy_r || rdata_r[7] == $past(busy_r))
        else $error("control bit 7 disagrees with busy");
    a_start_busy: assert property (ctl_wr && wdata[7] && !busy_r && !na |=> busy_r)
        else $error("start write did not raise busy");
    a_halt_stop: assert property (ctl_wr && !wdata[7] && busy_r |=> !busy_r)
        else $error("halt write did not drop busy");
    a_na_refused: assert property (ctl_wr && wdata[7] && !busy_r && na |=> !busy_r)
        else $error("unassigned shape code started a drawing");
    a_busy_ends: assert property ($rose(busy_r) |-> ##[1:200] !busy_r)
        else $error("drawing never completed");
    a_job_latch: assert property ($rose(busy_r) |-> job_shape_r == $past(wdata[4:1])
        && job_fill_r == $past(wdata[5]) && !job_close_r)
        else $error("job settings differ from start write");
    a_job_stable: assert property (busy_r && $past(busy_r) |-> $stable(job_x1_r)
        && $stable(job_y1_r) && $stable(job_x2_r) && $stable(job_y2_r)
        && $stable(job_x3_r) && $stable(job_y3_r) && $stable(job_shape_r))
        else $error("job changed while drawing");
    a_tri_dot: assert property ($rose(busy_r) && is_tri && p12 && p13
        |-> job_kind_r == `LPD_KIND_DOT)
        else $error("coincident triangle not drawn as dot");
    a_tri_line: assert property ($rose(busy_r) && is_tri && p12 && !p13
        |-> job_kind_r == `LPD_KIND_LINE)
        else $error("degenerate triangle not drawn as line");

    c_tri: cover property ($rose(busy_r) && is_tri && !p12 && !p13);
    c_halt: cover property (ctl_wr && !wdata[7] && busy_r);
    c_dot: cover property ($rose(busy_r) && is_tri && p12 && p13);
    c_irq: cover property ($rose(irq_r));
endmodule // lpd_draw_ctrl_monitor

bind lpd_draw_ctrl lpd_draw_ctrl_monitor #(.SEG_CYCLES(SEG_CYCLES)) i_lpd_draw_ctrl_monitor (
    .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_r(rdata_r),
    .busy_r(busy_r), .job_shape_r(job_shape_r), .job_fill_r(job_fill_r),
    .job_close_r(job_close_r), .job_kind_r(job_kind_r), .job_x1_r(job_x1_r),
    .job_y1_r(job_y1_r), .job_x2_r(job_x2_r), .job_y2_r(job_y2_r), .job_x3_r(job_x3_r),
    .job_y3_r(job_y3_r), .irq_r(irq_r));
`default_nettype wire

/* verif/lpd_draw_ctrl_tb.sv */
`default_nettype none
`include "lpd_map.vh"

module lpd_draw_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk;
    logic        nrst;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    wire  [7:0]  rdata_r;
    wire         busy_r;
    wire  [3:0]  job_shape_r;
    wire         job_fill_r;
    wire         job_close_r;
    wire  [2:0]  job_kind_r;
    wire  [12:0] job_x1_r, job_y1_r, job_x2_r, job_y2_r, job_x3_r, job_y3_r;
    wire         irq_r;
    int          n_mismatch;
    int          n_compared;
    int          cyc;
    logic [15:0] v;

    // Eight cycles a segment keeps every shape busy long enough to halt it
    lpd_draw_ctrl #(.SEG_CYCLES(8)) i_lpd_draw_ctrl (
        .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata_r(rdata_r), .busy_r(busy_r), .job_shape_r(job_shape_r),
        .job_fill_r(job_fill_r), .job_close_r(job_close_r), .job_kind_r(job_kind_r),
        .job_x1_r(job_x1_r), .job_y1_r(job_y1_r), .job_x2_r(job_x2_r), .job_y2_r(job_y2_r),
        .job_x3_r(job_x3_r), .job_y3_r(job_y3_r), .irq_r(irq_r));

    task automatic finish_test;
        $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata_r;
    endtask
    task automatic rd16(input logic [7:0] a, output logic [15:0] w);
        rd_reg(a, w[7:0]);
        rd_reg(a + 8'h01, w[15:8]);
    endtask
    // Ones in the unused high bits must be dropped
    task automatic set_pt(input logic [7:0] a, input logic [12:0] x, input logic [12:0] y);
        wr_reg(a, x[7:0]);
        wr_reg(a + 8'h01, {3'h7, x[12:8]});
        wr_reg(a + 8'h02, y[7:0]);
        wr_reg(a + 8'h03, {3'h7, y[12:8]});
    endtask
    task automatic wait_idle;
        repeat (500) if (busy_r === 1'b1) @(posedge clk);
        #1;
    endtask

    task automatic t_reset;
        for (int a = 8'h64; a <= 8'h76; a++) begin
            rd_reg(a[7:0], v[7:0]);
            chk(v[7:0], 8'h00);
        end
    endtask
    task automatic t_tri;
        wr_reg(8'h65, 8'hFE);
        wr_reg(8'h66, 8'h0F);
        set_pt(8'h68, 13'h1F34, 13'h0012);
        set_pt(8'h6C, 13'h0100, 13'h0200);
        set_pt(8'h70, 13'h0ABC, 13'h1000);
        rd16(8'h68, v);
        chk(v, 16'h1F34);
        wr_reg(`LPD_A_CTRL, 8'hA3);
        chk(busy_r, 1'b1);
        chk({job_shape_r, job_fill_r, job_close_r}, 6'h06);
        chk(job_kind_r, `LPD_KIND_TRI);
        chk(job_x1_r, 16'h1F34);
        chk(job_y1_r, 16'h0012);
        chk(job_x2_r, 16'h0100);
        chk(job_y2_r, 16'h0200);
        chk(job_x3_r, 16'h0ABC);
        chk(job_y3_r, 16'h1000);
        rd_reg(`LPD_A_CTRL, v[7:0]);
        chk(v[7:0], 8'hA2);
        wr_reg(8'h68, 8'h55);
        wr_reg(`LPD_A_CTRL, 8'h80);
        chk(job_x1_r, 16'h1F34);
        chk(job_shape_r, `LPD_SH_TRI);
        wait_idle;
        // The refused start still rewrote the fill and shape fields
        rd_reg(`LPD_A_CTRL, v[7:0]);
        chk(v[7:0], 8'h00);
        rd16(8'h65, v);
        chk(v, 16'h1001);
        rd_reg(`LPD_A_IRQ_STAT, v[7:0]);
        chk(v[7:0], 8'h05);
        chk(irq_r, 1'b0);
        wr_reg(`LPD_A_IRQ_MASK, 8'h01);
        repeat (2) @(posedge clk);
        chk(irq_r, 1'b1);
        wr_reg(`LPD_A_IRQ_STAT, 8'h07);
        repeat (2) @(posedge clk);
        chk(irq_r, 1'b0);
        rd_reg(`LPD_A_IRQ_STAT, v[7:0]);
        chk(v[7:0], 8'h00);
    endtask
    task automatic t_coinc;
        set_pt(8'h68, 13'h0100, 13'h0200);
        wr_reg(`LPD_A_CTRL, 8'h82);
        chk(job_kind_r, `LPD_KIND_LINE);
        wait_idle;
        set_pt(8'h70, 13'h0100, 13'h0200);
        wr_reg(`LPD_A_CTRL, 8'h82);
        chk(job_kind_r, `LPD_KIND_DOT);
        wait_idle;
        wr_reg(`LPD_A_IRQ_STAT, 8'h07);
    endtask
    task automatic t_shapes;
        logic ok;
        // Rectangle corners must differ in both X and Y
        set_pt(8'h6C, 13'h0300, 13'h0400);
        for (int s = 0; s < 16; s++) begin
            ok = s != 10 && s != 11;
            wr_reg(`LPD_A_CTRL, {1'b1, 2'b00, s[3:0], 1'b0});
            chk(busy_r, ok);
            if (ok) chk(job_shape_r, s[3:0]);
            wr_reg(`LPD_A_CTRL, 8'h00);
            chk(busy_r, 1'b0);
        end
        rd_reg(`LPD_A_IRQ_STAT, v[7:0]);
        chk(v[7:0], 8'h06);
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            finish_test;
        end
    end
    initial begin
        nrst = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        t_reset;
        t_tri;
        t_coinc;
        t_shapes;
        finish_test;
    end
endmodule // lpd_draw_ctrl_tb
`default_nettype wire
